// ===== icil_far_model.sv
/*
 * Far side model: the six pipelines and the storage unit buffers.
 * Assumes dispatch pulses from the interlock and hold knobs from the bench.
 */
`timescale 1ns/10ps
`include "icil_map.svh"
module icil_far_model
	import icil_pkg::*;
#(
	parameter int LAT = 8	// Cycles one instruction runs in a pipe
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    disp_valid_i,
	input  wire logic [`ICIL_PIPE_W-1:0] disp_pipe_i,
	input  wire logic                    st_hold_i,	// Starve the store buffer
	input  wire logic                    ld_hold_i,	// Starve the load buffer
	output logic      [`ICIL_NPIPE-1:0]  cnp_o,
	output logic      [`ICIL_NPIPE-1:0]  done_o,
	output logic                         st_space_o,
	output logic                         ld_data_o
);
	int cnt_q [`ICIL_NPIPE];	// Cycles left per pipe

	// Buffer levels follow the bench knobs
	assign st_space_o = !st_hold_i;
	assign ld_data_o  = !ld_hold_i;

	////////////////////////////////////////////////////////////////////////
	// Pipe runs; a starved buffer freezes its pipe, as the real one would
	always @(posedge sys_clk_i or posedge sys_rst_i) begin
		for (int p = 0; p < `ICIL_NPIPE; p++) begin
			cnp_o[p]  <= 1'b0;
			done_o[p] <= 1'b0;
			if (sys_rst_i) begin
				cnt_q[p] <= 0;
			end else if (disp_valid_i && disp_pipe_i == p) begin
				cnt_q[p] <= LAT;
			end else if (cnt_q[p] > 0 && !(p == `ICIL_PIPE_VST && st_hold_i)
					&& !(p == `ICIL_PIPE_VLD && ld_hold_i)) begin
				cnt_q[p]  <= cnt_q[p] - 1;
				cnp_o[p]  <= (cnt_q[p] == 3);
				done_o[p] <= (cnt_q[p] == 1);
			end
		end
	end
endmodule

// ===== icil_map.svh
/*
 * Constant map of the instruction conflict interlock: widths, pipe codes,
 * reset values. Assumes inclusion by the package and the design modules.
 */
`ifndef ICIL_MAP_SVH
`define ICIL_MAP_SVH
`define ICIL_REG_W     4
`define ICIL_NREG      16
`define ICIL_SLOT_W    8
`define ICIL_NPIPE     6
`define ICIL_PIPE_W    3
`define ICIL_GREG_W    36
`define ICIL_CHK_W     36
`define ICIL_PIPE_ADD  3'h0
`define ICIL_PIPE_MUL  3'h1
`define ICIL_PIPE_MOVE 3'h2
`define ICIL_PIPE_VLD  3'h3
`define ICIL_PIPE_VST  3'h4
`define ICIL_PIPE_SCTL 3'h5
`define ICIL_RST_SB    16'h0000
`define ICIL_RST_SLOTS 8'h00
`define ICIL_RST_CHK   36'h0_0000_0000
`define ICIL_RST_HALF  18'h0_0000
`endif

// ===== icil_pipe_track.sv
/*
 * Execution phase tracker for one pipeline: holds time slot
 * reservations and flags execution stalls. Assumes one start per run.
 */
`timescale 1ns/10ps
`include "icil_map.svh"
module icil_pipe_track
	import icil_pkg::*;
#(
	parameter int SLOT_W = `ICIL_SLOT_W
) (
	input  wire logic              sys_clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              start_i,	// Dispatched to this pipe
	input  wire logic [SLOT_W-1:0] slots_i,	// Slots to reserve
	input  wire logic              elem_busy_i,	// Prior user of element
	input  wire logic              res_ok_i,	// Buffer space or data
	input  wire logic              cnp_i,	// Conflict not possible
	input  wire logic              done_i,	// Instruction finished
	output logic                   busy_o,
	output logic                   stall_o,
	output logic      [SLOT_W-1:0] rsvd_o
);
	// Elaboration check: a tracker with no slot bits cannot reserve anything
	if (SLOT_W < 1) begin : g_bad_slot_w
		$error("SLOT_W must be positive");
	end

	icil_ex_state_t    st_q, st_d;		// Tracker state
	logic [SLOT_W-1:0] rsvd_q, rsvd_d;	// Held slots
	logic              stall_q, stall_d;	// Execution stall

	////////////////////////////////////////////////////////////////
	// Next state; detection only once dispatched
	always_comb begin
		st_d    = st_q;
		rsvd_d  = rsvd_q;
		stall_d = 1'b0;
		unique case (st_q)
			EX_IDLE: begin
				if (start_i) begin
					st_d   = EX_RUN;
					rsvd_d = slots_i;
				end
			end
			EX_RUN, EX_FREE: begin
				// Element usage and buffer conflicts, resolved here
				stall_d = elem_busy_i | ~res_ok_i;
				if (done_i) begin
					st_d   = EX_IDLE;
					rsvd_d = '0;
				end else if (cnp_i && st_q == EX_RUN) begin
					// Early release lets later work overlap
					st_d   = EX_FREE;
					rsvd_d = '0;
				end
			end
		endcase
	end

	// Register stage
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q    <= EX_IDLE;
			rsvd_q  <= '0;
			stall_q <= 1'b0;
		end else begin
			st_q    <= st_d;
			rsvd_q  <= rsvd_d;
			stall_q <= stall_d;
		end
	end

	assign busy_o  = (st_q != EX_IDLE);
	assign stall_o = stall_q;
	assign rsvd_o  = rsvd_q;

	////////////////////////////////////////////////////////////////
	// Checks
	property p_release;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(st_q == EX_RUN && cnp_i) |=> (rsvd_q == '0);
	endproperty
	a_release: assert property (p_release) else $error("slots not released");

	property p_elem;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(st_q != EX_IDLE && elem_busy_i) |=> stall_q;
	endproperty
	a_elem: assert property (p_elem) else $error("element use not stalled");

	property p_idle_quiet;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(st_q == EX_IDLE && !start_i) |=> !stall_q ##0 rsvd_q == '0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle pipe acts");
endmodule

// ===== icil_pkg.sv
/*
 * Types shared by the interlock modules.
 * Assumes icil_map.svh is reachable on the include path.
 */
`include "icil_map.svh"
package icil_pkg;
	// Execution tracker states
	typedef enum logic [1:0] {
		EX_IDLE = 2'b00,	// Pipe free
		EX_RUN  = 2'b01,	// Running, time slots held
		EX_FREE = 2'b10		// Running, time slots released early
	} icil_ex_state_t;

	// One held instruction
	typedef struct packed {
		logic                      vec;		// Vector instruction
		logic [`ICIL_PIPE_W-1:0]   pipe;	// Target pipeline
		logic                      has_dst;	// Writes a register
		logic [`ICIL_REG_W-1:0]    dst;		// Destination register
		logic [`ICIL_REG_W-1:0]    src;		// Source register
		logic [`ICIL_SLOT_W-1:0]   slots;	// Time slots needed
		logic                      mult;	// Uses scalar multiplier
		logic                      wreg;	// Needs working register
		logic                      mchg;	// May change mode
		logic                      lst;		// Store to local storage
		logic                      opnd;	// Storage operand requested
		logic                      vop;		// Vector element operand
	} icil_instr_t;
endpackage

// ===== icil_top.sv
/*
 * Instruction conflict interlock: issue, dispatch and execution
 * conflicts, plus status deposit and handler base save.
 * Assumes the pipelines and storage unit report completions as pulses.
 */
`timescale 1ns/10ps
`include "icil_map.svh"
module icil_top
	import icil_pkg::*;
#(
	parameter int NREG   = `ICIL_NREG,
	parameter int SLOT_W = `ICIL_SLOT_W,
	parameter int GREG_W = `ICIL_GREG_W
) (
	input  wire logic                     sys_clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     iss_valid_i,	// Held until ack
	input  wire logic                     iss_vec_i,
	input  wire logic [`ICIL_PIPE_W-1:0]  iss_pipe_i,
	input  wire logic                     iss_has_dst_i,
	input  wire logic [`ICIL_REG_W-1:0]   iss_dst_i,
	input  wire logic [`ICIL_REG_W-1:0]   iss_src_i,
	input  wire logic [SLOT_W-1:0]        iss_slots_i,
	input  wire logic                     iss_mult_i,
	input  wire logic                     iss_wreg_i,
	input  wire logic                     iss_mchg_i,
	input  wire logic                     iss_lst_i,
	input  wire logic                     iss_opnd_i,
	input  wire logic                     iss_vop_i,
	input  wire logic [NREG-1:0]          reg_wr_done_i,
	input  wire logic [NREG-1:0]          reg_rd_done_i,
	input  wire logic                     mult_done_i,
	input  wire logic                     wreg_release_i,
	input  wire logic                     opnd_arrive_i,
	input  wire logic                     vop_arrive_i,
	input  wire logic                     lst_done_i,
	input  wire logic [`ICIL_NPIPE-1:0]   pipe_busy_i,
	input  wire logic [`ICIL_NPIPE-1:0]   elem_busy_i,
	input  wire logic [`ICIL_NPIPE-1:0]   cnp_i,
	input  wire logic [`ICIL_NPIPE-1:0]   pipe_done_i,
	input  wire logic                     st_buf_space_i,
	input  wire logic                     ld_buf_data_i,
	input  wire logic [`ICIL_CHK_W-1:0]   stor_chk_i,
	input  wire logic [`ICIL_CHK_W-1:0]   proc_chk_i,
	input  wire logic                     hsr_clr_i,
	input  wire logic                     base_save_i,
	input  wire logic [GREG_W-1:0]        base_greg_i,
	output logic                          iss_ack_o,
	output logic                          iss_stall_o,
	output logic                          disp_valid_o,
	output logic [`ICIL_PIPE_W-1:0]       disp_pipe_o,
	output logic                          disp_ooo_o,
	output logic                          disp_stall_o,
	output logic [`ICIL_NPIPE-1:0]        exe_stall_o,
	output logic [SLOT_W-1:0]             slots_rsvd_o,
	output logic [`ICIL_CHK_W-1:0]        hsr2_o,
	output logic [`ICIL_CHK_W-1:0]        hsr3_o,
	output logic [GREG_W/2-1:0]           sreg3_o
);
	// Elaboration checks: scoreboards and the held record fix NREG and SLOT_W; the base save halves GREG_W
	if (NREG != (1 << `ICIL_REG_W)) begin : g_bad_nreg
		$error("NREG must match register field");
	end
	if (SLOT_W != `ICIL_SLOT_W) begin : g_bad_slot_w
		$error("SLOT_W must match instruction record");
	end
	if (GREG_W < 2 || GREG_W % 2 != 0) begin : g_bad_greg_w
		$error("GREG_W must be even");
	end

	////////////////////////////////////////////////////////////////
	// State
	logic [NREG-1:0]         wpend_q, wpend_d;	// Pending destinations
	logic [NREG-1:0]         rpend_q, rpend_d;	// Pending vector reads
	logic [1:0]              sv_q, sv_d;		// Slot valid, 0 is older
	icil_instr_t             se_q [2];		// Held instructions
	icil_instr_t             se_d [2];
	logic                    mult_q, mult_d;	// Multiplier busy
	logic                    own_q, own_d;		// Working register owned
	logic                    opw_q, opw_d;		// Storage operand awaited
	logic                    vopw_q, vopw_d;	// Vector operand awaited
	logic                    lstp_q, lstp_d;	// Local store in flight
	logic [`ICIL_REG_W-1:0]  lstr_q, lstr_d;	// Its register
	logic                    ack_q, ack_d;
	logic                    istl_q, istl_d;
	logic                    dv_q, dv_d;
	logic [`ICIL_PIPE_W-1:0] dp_q, dp_d;
	logic                    ooo_q, ooo_d;
	logic                    dstl_q, dstl_d;
	logic [`ICIL_CHK_W-1:0]  hsr2_q, hsr2_d, hsr3_q, hsr3_d;
	logic [GREG_W/2-1:0]     sr3_q, sr3_d;

	logic [`ICIL_NPIPE-1:0]  tr_busy;		// Tracker busy
	logic [SLOT_W-1:0]       tr_rsvd [`ICIL_NPIPE];
	logic [SLOT_W-1:0]       rsvd;			// All held slots
	logic                    quiet;			// No register, pipe or multiplier work in flight
	logic                    acc, fire0, fire1;
	logic                    c_ds, c_sd, c_dd, c_q;
	icil_instr_t             nw, fe;		// New and fired entry
	logic [`ICIL_NPIPE-1:0]  start;

	// Combined dispatch conflict of one held entry; any cause holds it
	function automatic logic disp_blocked(input icil_instr_t e);
		logic b;
		b = 1'b0;
		b |= e.vec & (pipe_busy_i[e.pipe] | tr_busy[e.pipe]);
		b |= e.mult & mult_q;
		b |= |(e.slots & rsvd);
		b |= e.wreg & own_q;
		b |= e.opnd & opw_q;
		b |= e.vop & vopw_q;
		b |= lstp_q & (e.src == lstr_q);
		b |= e.mchg & ~quiet;
		return b;
	endfunction

	////////////////////////////////////////////////////////////////
	// Execution trackers, one per pipeline
	for (genvar p = 0; p < `ICIL_NPIPE; p++) begin : g_trk
		logic res_ok;	// Buffer condition of this pipe
		assign res_ok = (p == int'(`ICIL_PIPE_VST)) ? st_buf_space_i :
		                (p == int'(`ICIL_PIPE_VLD)) ? ld_buf_data_i :
		                1'b1;
		icil_pipe_track #(.SLOT_W(SLOT_W)) u_trk (
			.sys_clk_i   (sys_clk_i),
			.sys_rst_i   (sys_rst_i),
			.start_i     (start[p]),
			.slots_i     (fe.slots),
			.elem_busy_i (elem_busy_i[p]),
			.res_ok_i    (res_ok),
			.cnp_i       (cnp_i[p]),
			.done_i      (pipe_done_i[p]),
			.busy_o      (tr_busy[p]),
			.stall_o     (exe_stall_o[p]),
			.rsvd_o      (tr_rsvd[p])
		);
	end

	// Reservation union and quiescence
	always_comb begin
		rsvd = '0;
		for (int p = 0; p < `ICIL_NPIPE; p++) begin
			rsvd |= tr_rsvd[p];
		end
		quiet = ~|wpend_q & ~|rpend_q & ~|pipe_busy_i & ~|tr_busy & ~mult_q;
	end

	////////////////////////////////////////////////////////////////
	// Issue and dispatch: next values
	always_comb begin
		nw      = '{iss_vec_i, iss_pipe_i, iss_has_dst_i, iss_dst_i, iss_src_i,
		            iss_slots_i, iss_mult_i, iss_wreg_i, iss_mchg_i, iss_lst_i,
		            iss_opnd_i, iss_vop_i};
		// Issue class checks against the scoreboards
		c_ds    = wpend_q[iss_src_i];
		c_sd    = iss_has_dst_i & rpend_q[iss_dst_i];
		c_dd    = iss_has_dst_i & wpend_q[iss_dst_i];
		c_q     = sv_q[1];
		acc     = iss_valid_i & ~ack_q & ~(c_ds | c_sd | c_dd | c_q);
		// Older entry first; a vector bypass needs no overlap
		fire0   = sv_q[0] & ~disp_blocked(se_q[0]);
		fire1   = ~fire0 & sv_q[1] & se_q[1].vec & se_q[0].vec &
		          ~disp_blocked(se_q[1]) &
		          ~(se_q[0].has_dst & (se_q[1].src == se_q[0].dst)) &
		          ~(se_q[1].has_dst & (se_q[1].dst == se_q[0].src)) &
		          ~(se_q[1].has_dst & se_q[0].has_dst &
		            (se_q[1].dst == se_q[0].dst)) &
		          ~se_q[1].mchg & ~se_q[0].mchg;
		fe      = fire0 ? se_q[0] : se_q[1];
		start   = '0;
		if (fire0 | fire1) begin
			start[fe.pipe] = 1'b1;
		end
		sv_d    = sv_q;
		se_d    = se_q;
		if (fire0) begin
			sv_d  = {1'b0, sv_q[1]};
			se_d[0] = se_q[1];
		end else if (fire1) begin
			sv_d[1] = 1'b0;
		end
		if (acc) begin
			if (!sv_d[0]) begin
				sv_d[0] = 1'b1;
				se_d[0] = nw;
			end else begin
				sv_d[1] = 1'b1;
				se_d[1] = nw;
			end
		end
		// Scoreboards; a set wins over a clear in the same cycle
		wpend_d = wpend_q & ~reg_wr_done_i;
		rpend_d = rpend_q & ~reg_rd_done_i;
		if (acc && iss_has_dst_i) begin
			wpend_d[iss_dst_i] = 1'b1;
		end
		if (acc && iss_vec_i) begin
			rpend_d[iss_src_i] = 1'b1;
		end
		mult_d  = ((fire0 | fire1) & fe.mult) | (mult_q & ~mult_done_i);
		own_d   = ((fire0 | fire1) & fe.wreg) | (own_q & ~wreg_release_i);
		opw_d   = (acc & iss_opnd_i) | (opw_q & ~opnd_arrive_i);
		vopw_d  = (acc & iss_vop_i) | (vopw_q & ~vop_arrive_i);
		lstp_d  = ((fire0 | fire1) & fe.lst) | (lstp_q & ~lst_done_i);
		lstr_d  = ((fire0 | fire1) & fe.lst) ? fe.dst : lstr_q;
		ack_d   = acc;
		istl_d  = iss_valid_i & ~ack_q & ~acc;
		dv_d    = fire0 | fire1;
		dp_d    = (fire0 | fire1) ? fe.pipe : dp_q;
		ooo_d   = fire1;
		dstl_d  = sv_q[0] & ~fire0 & ~fire1;
	end

	// Register stage for issue and dispatch
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wpend_q <= `ICIL_RST_SB;
			rpend_q <= `ICIL_RST_SB;
			sv_q    <= 2'h0;
			se_q[0] <= '0;
			se_q[1] <= '0;
			mult_q  <= 1'b0;
			own_q   <= 1'b0;
			opw_q   <= 1'b0;
			vopw_q  <= 1'b0;
			lstp_q  <= 1'b0;
			lstr_q  <= '0;
			ack_q   <= 1'b0;
			istl_q  <= 1'b0;
			dv_q    <= 1'b0;
			dp_q    <= '0;
			ooo_q   <= 1'b0;
			dstl_q  <= 1'b0;
		end else begin
			wpend_q <= wpend_d;
			rpend_q <= rpend_d;
			sv_q    <= sv_d;
			se_q    <= se_d;
			mult_q  <= mult_d;
			own_q   <= own_d;
			opw_q   <= opw_d;
			vopw_q  <= vopw_d;
			lstp_q  <= lstp_d;
			lstr_q  <= lstr_d;
			ack_q   <= ack_d;
			istl_q  <= istl_d;
			dv_q    <= dv_d;
			dp_q    <= dp_d;
			ooo_q   <= ooo_d;
			dstl_q  <= dstl_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status deposit and handler base save
	always_comb begin
		// Deposits win over a clear; mode does not matter
		hsr2_d = (hsr_clr_i ? `ICIL_RST_CHK : hsr2_q) | stor_chk_i;
		hsr3_d = (hsr_clr_i ? `ICIL_RST_CHK : hsr3_q) | proc_chk_i;
		// Only the left half of the base register fits
		sr3_d  = base_save_i ? base_greg_i[GREG_W-1:GREG_W/2] : sr3_q;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hsr2_q <= `ICIL_RST_CHK;
			hsr3_q <= `ICIL_RST_CHK;
			sr3_q  <= `ICIL_RST_HALF;
		end else begin
			hsr2_q <= hsr2_d;
			hsr3_q <= hsr3_d;
			sr3_q  <= sr3_d;
		end
	end

	assign iss_ack_o    = ack_q;
	assign iss_stall_o  = istl_q;
	assign disp_valid_o = dv_q;
	assign disp_pipe_o  = dp_q;
	assign disp_ooo_o   = ooo_q;
	assign disp_stall_o = dstl_q;
	assign slots_rsvd_o = rsvd;
	assign hsr2_o       = hsr2_q;
	assign hsr3_o       = hsr3_q;
	assign sreg3_o      = sr3_q;

	////////////////////////////////////////////////////////////////
	// Checks
	property p_dd_block;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(iss_has_dst_i && wpend_q[iss_dst_i]) |=> !ack_q;
	endproperty
	a_dd_block: assert property (p_dd_block) else $error("issue over pending dst");

	property p_queue;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		sv_q[1] |=> !ack_q;
	endproperty
	a_queue: assert property (p_queue) else $error("issue with full queue");

	property p_mult;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		mult_q |-> !((fire0 | fire1) && fe.mult);
	endproperty
	a_mult: assert property (p_mult) else $error("multiply while busy");

	property p_slots;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(fire0 | fire1) |-> ((fe.slots & rsvd) == '0);
	endproperty
	a_slots: assert property (p_slots) else $error("slot double booked");

	property p_mode;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		((fire0 | fire1) && fe.mchg) |-> quiet;
	endproperty
	a_mode: assert property (p_mode) else $error("mode change not quiet");

	property p_ooo;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		fire1 |-> sv_q[0] && !(se_q[0].has_dst && se_q[1].src == se_q[0].dst);
	endproperty
	a_ooo: assert property (p_ooo) else $error("bypass with overlap");

	property p_hsr;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		(stor_chk_i != '0) |=> ((hsr2_q & $past(stor_chk_i)) == $past(stor_chk_i));
	endproperty
	a_hsr: assert property (p_hsr) else $error("status lost");

	property p_save;
		@(posedge sys_clk_i) disable iff (sys_rst_i)
		base_save_i |=> sreg3_o == $past(base_greg_i[GREG_W-1:GREG_W/2]);
	endproperty
	a_save: assert property (p_save) else $error("base half not saved");
endmodule

// ===== icil_top_tb.sv
/*
 * Self-checking bench of the interlock, one task per scenario.
 * Assumes icil_top and icil_far_model; far pipes end runs on their own.
 */
`timescale 1ns/10ps
`include "icil_map.svh"
module icil_top_tb
	import icil_pkg::*;
;
	localparam int  LAT = 8;	// Pipe run length in the model
	localparam time DLY = 2ns;	// Input skew after the edge
	logic               clk, rst, iss_valid, st_hold, ld_hold;
	logic               mult_done, wreg_rel, opnd_arr, vop_arr, lst_done, hsr_clr, base_save;
	icil_instr_t        ins;	// Fields of the issue request
	logic [15:0]        wr_done, rd_done;
	logic [5:0]         pipe_busy, elem_busy, cnp, pipe_done, exe_stall;
	logic [35:0]        stor_chk, proc_chk, base_greg, hsr2, hsr3;
	logic               st_space, ld_data, ack, iss_stall, dv, ooo, dstall;
	logic [2:0]         dpipe;
	logic [7:0]         rsvd;
	logic [17:0]        sreg3;
	int                 err_count, checks_done, cyc;

	icil_top uut (.sys_clk_i(clk), .sys_rst_i(rst), .iss_valid_i(iss_valid),
		.iss_vec_i(ins.vec), .iss_pipe_i(ins.pipe), .iss_has_dst_i(ins.has_dst),
		.iss_dst_i(ins.dst), .iss_src_i(ins.src), .iss_slots_i(ins.slots),
		.iss_mult_i(ins.mult), .iss_wreg_i(ins.wreg), .iss_mchg_i(ins.mchg),
		.iss_lst_i(ins.lst), .iss_opnd_i(ins.opnd), .iss_vop_i(ins.vop),
		.reg_wr_done_i(wr_done), .reg_rd_done_i(rd_done), .mult_done_i(mult_done),
		.wreg_release_i(wreg_rel), .opnd_arrive_i(opnd_arr), .vop_arrive_i(vop_arr),
		.lst_done_i(lst_done), .pipe_busy_i(pipe_busy), .elem_busy_i(elem_busy),
		.cnp_i(cnp), .pipe_done_i(pipe_done), .st_buf_space_i(st_space),
		.ld_buf_data_i(ld_data), .stor_chk_i(stor_chk), .proc_chk_i(proc_chk),
		.hsr_clr_i(hsr_clr), .base_save_i(base_save), .base_greg_i(base_greg),
		.iss_ack_o(ack), .iss_stall_o(iss_stall), .disp_valid_o(dv), .disp_pipe_o(dpipe),
		.disp_ooo_o(ooo), .disp_stall_o(dstall), .exe_stall_o(exe_stall),
		.slots_rsvd_o(rsvd), .hsr2_o(hsr2), .hsr3_o(hsr3), .sreg3_o(sreg3));
	icil_far_model #(.LAT(LAT)) far (.sys_clk_i(clk), .sys_rst_i(rst), .disp_valid_i(dv),
		.disp_pipe_i(dpipe), .st_hold_i(st_hold), .ld_hold_i(ld_hold), .cnp_o(cnp),
		.done_o(pipe_done), .st_space_o(st_space), .ld_data_o(ld_data));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#DLY;
	endtask
	function automatic icil_instr_t mk(input logic v, input logic [2:0] p, input logic h,
			input logic [3:0] d, input logic [3:0] s, input logic [7:0] sl);
		mk = '0;
		mk.vec = v;
		mk.pipe = p;
		mk.has_dst = h;
		mk.dst = d;
		mk.src = s;
		mk.slots = sl;
	endfunction
	// Request held until ack is seen, then dropped
	task automatic issue(input icil_instr_t i);
		ins = i;
		iss_valid = 1'b1;
		for (int n = 0; n < 40 && ack !== 1'b1; n++) tick(1);
		check(ack, 1'b1, "issue ack");
		iss_valid = 1'b0;
	endtask
	task automatic wait_disp(input int bound, output logic ok);
		ok = 1'b0;
		for (int n = 0; n < bound && !ok; n++) begin
			tick(1);
			ok = (dv === 1'b1);
		end
	endtask
	task automatic zero_pulses;
		{wr_done, rd_done, mult_done, wreg_rel, opnd_arr, vop_arr, lst_done} = '0;
	endtask
	// Retire everything outstanding so scenarios start clean
	task automatic clear_all;
		{wr_done, rd_done, mult_done, wreg_rel, opnd_arr, vop_arr, lst_done} = '1;
		tick(1);
		zero_pulses();
		tick(LAT + 4);
	endtask
	// Older a, younger b held by a until the release pulse rel
	task automatic conflict(input icil_instr_t a, input icil_instr_t b, input int rel,
			input int r, output logic s_iss, output logic s_disp, output logic ok);
		issue(a);
		tick(2);
		fork
			issue(b);
			begin
				tick(4);
				s_iss = iss_stall;
				s_disp = dstall;
				case (rel)
					0: wr_done[r] = 1'b1;
					1: rd_done[r] = 1'b1;
					2: mult_done = 1'b1;
					3: wreg_rel = 1'b1;
					4: opnd_arr = 1'b1;
					5: vop_arr = 1'b1;
					default: lst_done = 1'b1;
				endcase
				tick(1);
				zero_pulses();
				wait_disp(LAT + 12, ok);
			end
		join
		clear_all();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_reset;
		check({ack, dv, exe_stall, rsvd}, '0, "outputs after reset");
		check(hsr2 | hsr3, '0, "status after reset");
		check(sreg3, '0, "save word after reset");
	endtask
	task automatic s_status;
		stor_chk = 36'h0_0000_0005;
		proc_chk = 36'h8_0000_0000;
		tick(1);
		{stor_chk, proc_chk} = '0;
		tick(1);
		check(hsr2, 36'h0_0000_0005, "storage deposit");
		check(hsr3, 36'h8_0000_0000, "processor deposit");
		stor_chk = 36'h0_0000_0100;
		hsr_clr = 1'b1;
		tick(1);
		{stor_chk, hsr_clr} = '0;
		tick(1);
		check(hsr2 | hsr3, 36'h0_0000_0100, "set over clear");
		hsr_clr = 1'b1;
		tick(1);
		hsr_clr = 1'b0;
		tick(1);
		check(hsr2 | hsr3, '0, "clear");
	endtask
	task automatic s_base;
		base_greg = 36'hA_BCDE_1234;
		base_save = 1'b1;
		tick(1);
		base_save = 1'b0;
		base_greg = '0;
		tick(1);
		check(sreg3, 36'hA_BCDE_1234 >> 18, "left half saved");
	endtask
	// Walk through all phases, then time slot hold and early release
	task automatic s_walk_slots;
		logic ok;
		issue(mk(1, `ICIL_PIPE_ADD, 1, 1, 2, 8'h03));
		tick(1);
		check(dv, 1'b1, "dispatch after issue");
		check(dpipe, `ICIL_PIPE_ADD, "dispatch pipe");
		check(rsvd, 8'h03, "slots reserved");
		issue(mk(1, `ICIL_PIPE_MOVE, 1, 3, 4, 8'h01));
		tick(1);
		check(dstall, 1'b1, "slot busy holds");
		wait_disp(LAT + 6, ok);
		check(ok, 1'b1, "dispatch after release");
		check(rsvd, 8'h01, "early release");
		clear_all();
	endtask
	task automatic s_reg_hazards;
		logic si, sd, ok;
		conflict(mk(0, `ICIL_PIPE_SCTL, 1, 5, 0, 0), mk(0, `ICIL_PIPE_MUL, 1, 6, 5, 0),
			0, 5, si, sd, ok);
		check({si, ok}, 2'b11, "dest then source");
		conflict(mk(1, `ICIL_PIPE_MOVE, 0, 0, 9, 0), mk(0, `ICIL_PIPE_SCTL, 1, 9, 0, 0),
			1, 9, si, sd, ok);
		check({si, ok}, 2'b11, "source then dest");
		conflict(mk(0, `ICIL_PIPE_SCTL, 1, 7, 0, 0), mk(0, `ICIL_PIPE_MUL, 1, 7, 1, 0),
			0, 7, si, sd, ok);
		check({si, ok}, 2'b11, "dest then dest");
	endtask
	task automatic s_facility;
		icil_instr_t a, b;
		logic si, sd, ok;
		a = mk(0, `ICIL_PIPE_SCTL, 0, 0, 0, 0);
		b = mk(0, `ICIL_PIPE_MUL, 0, 0, 0, 0);
		a.mult = 1'b1;
		b.mult = 1'b1;
		conflict(a, b, 2, 0, si, sd, ok);
		check({si, sd, ok}, 3'b011, "multiplier busy");
		b.mult = 1'b0;
		b.mchg = 1'b1;
		conflict(a, b, 2, 0, si, sd, ok);
		check({sd, ok}, 2'b11, "mode change waits");
		a.mult = 1'b0;
		a.wreg = 1'b1;
		b = a;
		b.pipe = `ICIL_PIPE_MUL;
		conflict(a, b, 3, 0, si, sd, ok);
		check({sd, ok}, 2'b11, "working register order");
	endtask
	task automatic s_operands;
		icil_instr_t a, b;
		logic si, sd, ok;
		a = mk(0, `ICIL_PIPE_MUL, 0, 3, 0, 0);
		b = mk(0, `ICIL_PIPE_SCTL, 0, 0, 3, 0);
		b.opnd = 1'b1;
		conflict(a, b, 4, 0, si, sd, ok);
		check({sd, ok}, 2'b11, "storage operand");
		b.opnd = 1'b0;
		b.vop = 1'b1;
		conflict(a, b, 5, 0, si, sd, ok);
		check({sd, ok}, 2'b11, "vector operand");
		b.vop = 1'b0;
		a.lst = 1'b1;
		conflict(a, b, 6, 0, si, sd, ok);
		check({si | sd, ok}, 2'b11, "local store result");
	endtask
	task automatic s_bypass;
		logic ok;
		pipe_busy[`ICIL_PIPE_ADD] = 1'b1;
		issue(mk(1, `ICIL_PIPE_ADD, 1, 1, 2, 8'h01));
		tick(1);
		issue(mk(1, `ICIL_PIPE_MOVE, 1, 3, 4, 8'h02));
		wait_disp(4, ok);
		check({ok, ooo, dpipe}, {2'b11, `ICIL_PIPE_MOVE}, "bypass start");
		tick(2);
		check(dstall, 1'b1, "busy pipe holds");
		pipe_busy = '0;
		wait_disp(4, ok);
		check({ok, ooo, dpipe}, {2'b10, `ICIL_PIPE_ADD}, "held one starts");
		clear_all();
	endtask
	task automatic s_exec;
		logic [2:0] pc [3];
		pc = '{`ICIL_PIPE_VST, `ICIL_PIPE_VLD, `ICIL_PIPE_ADD};
		for (int k = 0; k < 3; k++) begin
			{st_hold, ld_hold, elem_busy[0]} = 3'b100 >> k;
			tick(2);
			check(exe_stall, '0, "no stall before dispatch");
			issue(mk(1, pc[k], 0, 0, 11, 8'h10));
			tick(3);
			check(exe_stall, 6'h01 << pc[k], "pipe stalls");
			{st_hold, ld_hold, elem_busy} = '0;
			tick(2);
			check(exe_stall, '0, "pipe resumes");
			clear_all();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{rst, iss_valid, st_hold, ld_hold, hsr_clr, base_save} = 6'b100000;
		{wr_done, rd_done, mult_done, wreg_rel, opnd_arr, vop_arr, lst_done} = '0;
		{pipe_busy, elem_busy, stor_chk, proc_chk, base_greg} = '0;
		{err_count, checks_done, cyc} = '0;
		ins = '0;
		repeat (5) @(posedge clk);
		#DLY rst = 1'b0;
		s_reset();
		s_status();
		s_base();
		s_walk_slots();
		s_reg_hazards();
		s_facility();
		s_operands();
		s_bypass();
		s_exec();
		report_and_stop();
	end
endmodule
